// ==== pkg/ccs_pkg.sv ====
package ccs_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SAFETY_IRQ = 8'h06;
    localparam logic [7:0] ADDR_THERM_RAIL = 8'h07;
    localparam logic [7:0] ADDR_CHG_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h09;
    // Reset values
    localparam logic [7:0] RST_SAFETY_IRQ = 8'hC0;
    localparam logic [7:0] RST_THERM_RAIL = 8'h37;
    localparam logic [7:0] RST_CHG_STATUS = 8'h00;
    localparam logic [7:0] RST_FAULT_STATUS = 8'h00;
    // Field positions, register 0x06
    localparam int BIT_NTC_EN = 7;
    localparam int BIT_SLOW_TMR = 6;
    localparam int BIT_SW_OFF = 5;
    localparam int BIT_PG_MASK = 4;
    localparam int BIT_DONE_MASK = 3;
    localparam int BIT_PHASE_MASK = 2;
    localparam int BIT_NTC_MASK = 1;
    localparam int BIT_OVP_MASK = 0;
    // Register 0x07
    localparam int BIT_BOARD_OT = 7;
    localparam int BIT_VIN_LOOP = 6;
    localparam int POS_TJ = 4;
    localparam int POS_RAIL = 0;
    // Register 0x08
    localparam int BIT_WD_EXP = 7;
    localparam int BIT_LIM_REL = 6;
    localparam int BIT_LIM_BOOST = 5;
    localparam int POS_PHASE = 3;
    localparam int BIT_PATH_LIM = 2;
    localparam int BIT_IN_GOOD = 1;
    localparam int BIT_TJ_LIM = 0;
    // Register 0x09
    localparam int POS_SHIP_DGL = 6;
    // Writable masks for partly read-only registers
    localparam logic [7:0] WMASK_CHG_STATUS = 8'h60;
    localparam logic [7:0] WMASK_FAULT_STATUS = 8'hC0;
    // Watchdog-resettable bits per register
    localparam logic [7:0] WDMASK_SAFETY_IRQ = 8'hDF;
    localparam logic [7:0] WDMASK_THERM_RAIL = 8'hF0;
    localparam logic [7:0] WDMASK_CHG_STATUS = 8'h60;
    localparam logic [7:0] WDMASK_FAULT_STATUS = 8'h00;
    // Charge phase codes
    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_PRE = 2'h1;
    localparam logic [1:0] PHASE_FAST = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;
    // Safety timer prescale when slowed
    localparam logic [1:0] TMR_DIV_SLOW = 2'h1;
    // Watchdog period code meaning disabled
    localparam logic [1:0] WD_PERIOD_OFF = 2'h0;
endpackage

// ==== hdl/ccs_status_capture.sv ====
`timescale 1ns/1ps
// Registers live status inputs into the read-only fields
module ccs_status_capture (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wd_expired,
    input wire logic [1:0] charge_phase,
    input wire logic path_limit_active,
    input wire logic input_good_flag,
    input wire logic die_temp_limiting_flag,
    input wire logic input_fault_flag,
    input wire logic overheat_shutdown_flag,
    input wire logic cell_overvoltage_flag,
    input wire logic charge_timeout_flag,
    input wire logic [1:0] thermistor_range_flags,
    output logic [7:0] chg_ro,
    output logic [7:0] fault_ro
);
    typedef struct packed {
        logic [7:0] chg;
        logic [7:0] fault;
    } ccs_cap_t;

    ccs_cap_t st;
    ccs_cap_t next_st;

    always_comb begin
        next_st.chg = {wd_expired, 2'h0, charge_phase, path_limit_active,
                       input_good_flag, die_temp_limiting_flag};
        next_st.fault = {2'h0, input_fault_flag, overheat_shutdown_flag,
                         cell_overvoltage_flag, charge_timeout_flag,
                         thermistor_range_flags};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign chg_ro = st.chg;
    assign fault_ro = st.fault;
endmodule

// ==== hdl/ccs_safety_timer.sv ====
`timescale 1ns/1ps
// Safety timer tick prescaler: halves the tick rate in path limiting
module ccs_safety_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic base_tick,
    input wire logic slow_en,
    output logic timer_tick
);
    typedef struct packed {
        logic [1:0] div;
        logic tick;
    } ccs_tmr_t;

    ccs_tmr_t st;
    ccs_tmr_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (base_tick) begin
            if (slow_en && st.div != ccs_pkg::TMR_DIV_SLOW) begin
                next_st.div = st.div + 2'h1;
            end else begin
                next_st.div = 2'h0;
                next_st.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign timer_tick = st.tick;
endmodule

// ==== hdl/ccs_regs.sv ====
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module ccs_regs (
    input wire logic clk,
    input wire logic resetn,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Register reset request and watchdog expiry pulse
    input wire logic reg_reset_req,
    input wire logic watchdog_expire,
    input wire logic [1:0] watchdog_period,
    // Live status from the charger core
    input wire logic [1:0] charge_phase,
    input wire logic input_path_limiting,
    input wire logic input_good_flag,
    input wire logic die_temp_limiting_flag,
    input wire logic input_fault_flag,
    input wire logic overheat_shutdown_flag,
    input wire logic cell_overvoltage_flag,
    input wire logic charge_timeout_flag,
    input wire logic [1:0] thermistor_range_flags,
    // Raw interrupt events and safety timer base tick
    input wire logic ev_input_good,
    input wire logic ev_charge_done,
    input wire logic ev_thermistor,
    input wire logic ev_cell_overvoltage,
    input wire logic safety_base_tick,
    // Controls to the charger core
    output logic thermistor_monitor_enable,
    output logic safety_timer_tick,
    output logic battery_switch_off,
    output logic board_overheat_enable,
    output logic input_voltage_loop_enable,
    output logic [1:0] die_temp_limit_sel,
    output logic [3:0] load_rail_target,
    output logic input_limit_release,
    output logic input_limit_boost,
    output logic [1:0] ship_entry_delay_sel,
    output logic watchdog_active,
    output logic irq_event
);
    typedef enum logic [1:0] {
        CCS_IDLE,
        CCS_WRITE,
        CCS_READ
    } ccs_op_t;

    typedef struct packed {
        logic [7:0] safety;
        logic [7:0] therm;
        logic [7:0] chg_w;
        logic [7:0] fault_w;
        logic [7:0] rdata;
        logic rvalid;
        logic wd_flag;
        logic [1:0] last_phase;
        logic irq;
    } ccs_state_t;

    ccs_state_t st;
    ccs_state_t next_st;
    ccs_op_t op;
    logic [7:0] chg_ro;
    logic [7:0] fault_ro;
    logic phase_change;

    // Merges held writable bits with live read-only bits
    function automatic logic [7:0] ccs_merge(input logic [7:0] wbits,
                                             input logic [7:0] robits,
                                             input logic [7:0] wmask);
        ccs_merge = (wbits & wmask) | (robits & ~wmask);
    endfunction

    // Watchdog expiry restores only its own fields to default
    function automatic logic [7:0] ccs_wd_restore(input logic [7:0] cur,
                                                  input logic [7:0] rst,
                                                  input logic [7:0] wdm);
        ccs_wd_restore = (rst & wdm) | (cur & ~wdm);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    ccs_status_capture u_cap (
        .clk(clk),
        .resetn(resetn),
        .wd_expired(st.wd_flag),
        .charge_phase(charge_phase),
        .path_limit_active(input_path_limiting),
        .input_good_flag(input_good_flag),
        .die_temp_limiting_flag(die_temp_limiting_flag),
        .input_fault_flag(input_fault_flag),
        .overheat_shutdown_flag(overheat_shutdown_flag),
        .cell_overvoltage_flag(cell_overvoltage_flag),
        .charge_timeout_flag(charge_timeout_flag),
        .thermistor_range_flags(thermistor_range_flags),
        .chg_ro(chg_ro),
        .fault_ro(fault_ro)
    );

    ccs_safety_timer u_tmr (
        .clk(clk),
        .resetn(resetn),
        .base_tick(safety_base_tick),
        .slow_en(st.safety[ccs_pkg::BIT_SLOW_TMR] & input_path_limiting),
        .timer_tick(safety_timer_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        if (reg_wr) begin
            op = CCS_WRITE;
        end else if (reg_rd) begin
            op = CCS_READ;
        end else begin
            op = CCS_IDLE;
        end
    end

    // Phase change events cover not charging, pre-charge and charge only
    assign phase_change = (charge_phase != st.last_phase) &&
                          (charge_phase != ccs_pkg::PHASE_DONE);

    assign watchdog_active = (watchdog_period != ccs_pkg::WD_PERIOD_OFF);

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.irq = 1'b0;
        next_st.last_phase = charge_phase;
        case (op)
            CCS_WRITE: begin
                case (reg_addr)
                    ccs_pkg::ADDR_SAFETY_IRQ: next_st.safety = reg_wdata;
                    ccs_pkg::ADDR_THERM_RAIL: next_st.therm = reg_wdata;
                    ccs_pkg::ADDR_CHG_STATUS: begin
                        next_st.chg_w = reg_wdata & ccs_pkg::WMASK_CHG_STATUS;
                    end
                    ccs_pkg::ADDR_FAULT_STATUS: begin
                        next_st.fault_w = reg_wdata & ccs_pkg::WMASK_FAULT_STATUS;
                    end
                    default: begin
                    end
                endcase
            end
            CCS_READ: begin
                next_st.rvalid = 1'b1;
                case (reg_addr)
                    ccs_pkg::ADDR_SAFETY_IRQ: next_st.rdata = st.safety;
                    ccs_pkg::ADDR_THERM_RAIL: next_st.rdata = st.therm;
                    ccs_pkg::ADDR_CHG_STATUS: begin
                        next_st.rdata = ccs_merge(st.chg_w, chg_ro,
                                                  ccs_pkg::WMASK_CHG_STATUS);
                    end
                    ccs_pkg::ADDR_FAULT_STATUS: begin
                        next_st.rdata = ccs_merge(st.fault_w, fault_ro,
                                                  ccs_pkg::WMASK_FAULT_STATUS);
                    end
                    default: next_st.rdata = 8'h00;
                endcase
            end
            default: begin
            end
        endcase
        // Masked interrupt events, 0 lets through
        if ((ev_input_good && !st.safety[ccs_pkg::BIT_PG_MASK]) ||
            (ev_charge_done && !st.safety[ccs_pkg::BIT_DONE_MASK]) ||
            (ev_thermistor && !st.safety[ccs_pkg::BIT_NTC_MASK]) ||
            (ev_cell_overvoltage && !st.safety[ccs_pkg::BIT_OVP_MASK]) ||
            (phase_change && !st.safety[ccs_pkg::BIT_PHASE_MASK])) begin
            next_st.irq = 1'b1;
        end
        // Watchdog expiry: sticky flag, restore watchdog-reset fields
        if (watchdog_expire && watchdog_active) begin
            next_st.wd_flag = 1'b1;
            next_st.safety = ccs_wd_restore(next_st.safety, ccs_pkg::RST_SAFETY_IRQ,
                                            ccs_pkg::WDMASK_SAFETY_IRQ);
            next_st.therm = ccs_wd_restore(next_st.therm, ccs_pkg::RST_THERM_RAIL,
                                           ccs_pkg::WDMASK_THERM_RAIL);
            next_st.chg_w = ccs_wd_restore(next_st.chg_w, ccs_pkg::RST_CHG_STATUS,
                                           ccs_pkg::WDMASK_CHG_STATUS);
            next_st.fault_w = ccs_wd_restore(next_st.fault_w, ccs_pkg::RST_FAULT_STATUS,
                                             ccs_pkg::WDMASK_FAULT_STATUS);
        end
        // Register reset restores everything, including switch and rail
        if (reg_reset_req) begin
            next_st.safety = ccs_pkg::RST_SAFETY_IRQ;
            next_st.therm = ccs_pkg::RST_THERM_RAIL;
            next_st.chg_w = ccs_pkg::RST_CHG_STATUS;
            next_st.fault_w = ccs_pkg::RST_FAULT_STATUS;
            // Expiry in the same cycle wins over the clear
            next_st.wd_flag = watchdog_expire && watchdog_active;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st.safety <= ccs_pkg::RST_SAFETY_IRQ;
            st.therm <= ccs_pkg::RST_THERM_RAIL;
            st.chg_w <= ccs_pkg::RST_CHG_STATUS;
            st.fault_w <= ccs_pkg::RST_FAULT_STATUS;
            st.rdata <= 8'h00;
            st.rvalid <= 1'b0;
            st.wd_flag <= 1'b0;
            st.last_phase <= ccs_pkg::PHASE_IDLE;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign irq_event = st.irq;
    assign thermistor_monitor_enable = st.safety[ccs_pkg::BIT_NTC_EN];
    assign battery_switch_off = st.safety[ccs_pkg::BIT_SW_OFF];
    // Enable bits in register 0x07 are active low in the register
    assign board_overheat_enable = ~st.therm[ccs_pkg::BIT_BOARD_OT];
    assign input_voltage_loop_enable = ~st.therm[ccs_pkg::BIT_VIN_LOOP];
    assign die_temp_limit_sel = st.therm[ccs_pkg::POS_TJ +: 2];
    assign load_rail_target = st.therm[ccs_pkg::POS_RAIL +: 4];
    assign input_limit_release = st.chg_w[ccs_pkg::BIT_LIM_REL];
    assign input_limit_boost = st.chg_w[ccs_pkg::BIT_LIM_BOOST];
    assign ship_entry_delay_sel = st.fault_w[ccs_pkg::POS_SHIP_DGL +: 2];
endmodule

// ==== dv/ccs_regs_asserts.sv ====
`timescale 1ns/1ps
module ccs_regs_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_reset_req,
    input wire logic watchdog_expire,
    input wire logic [1:0] watchdog_period,
    input wire logic input_path_limiting,
    input wire logic safety_base_tick,
    input wire logic thermistor_monitor_enable,
    input wire logic safety_timer_tick,
    input wire logic battery_switch_off,
    input wire logic [3:0] load_rail_target,
    input wire logic input_limit_release,
    input wire logic input_limit_boost,
    input wire logic watchdog_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic wr6;
    logic wd_hit;
    // Reset request and expiry both beat a write, so keep them out
    assign wr6 = reg_wr && reg_addr == 8'h06 && !reg_reset_req && !watchdog_expire;
    assign wd_hit = watchdog_expire && watchdog_period != 2'h0 && !reg_reset_req;
    ////////////////////////////////////////////////////////////////////////////
    sw_write_a:
    assert property (wr6 |=> battery_switch_off == $past(reg_wdata[5])) else $error("sw wr");
    sw_keep_a:
    assert property (watchdog_expire && !reg_wr && !reg_reset_req |=> $stable(battery_switch_off))
        else $error("sw kept");
    ntc_wd_a:
    assert property (wd_hit |=> thermistor_monitor_enable) else $error("ntc wd");
    reg_rst_a:
    assert property (reg_reset_req |=> thermistor_monitor_enable && !battery_switch_off
        && load_rail_target == 4'h7) else $error("reg reset");
    rail_keep_a:
    assert property (watchdog_expire && !reg_wr && !reg_reset_req |=> $stable(load_rail_target))
        else $error("rail kept");
    lim_wd_a:
    assert property (wd_hit |=> !input_limit_release && !input_limit_boost) else $error("lim wd");
    wd_off_a:
    assert property (watchdog_expire && watchdog_period == 2'h0 && !reg_wr && !reg_reset_req
        |=> $stable(thermistor_monitor_enable) && $stable(input_limit_release)) else $error("wd off");
    wd_gate_a:
    assert property (watchdog_active == (watchdog_period != 2'h0)) else $error("wd gate");
    tick_pass_a:
    assert property (safety_base_tick && !input_path_limiting |=> safety_timer_tick)
        else $error("tick");
endmodule
bind ccs_regs ccs_regs_asserts i_chk (
    .clk, .resetn, .reg_wr, .reg_addr, .reg_wdata, .reg_reset_req, .watchdog_expire,
    .watchdog_period, .input_path_limiting, .safety_base_tick, .thermistor_monitor_enable,
    .safety_timer_tick, .battery_switch_off, .load_rail_target, .input_limit_release,
    .input_limit_boost, .watchdog_active
);

// ==== dv/ccs_host_model.sv ====
`timescale 1ns/1ps
// Host side of the register port, one request at a time
module ccs_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, 8'hFF, 8'h00};
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(posedge clk);
        #1;
        // Inverted idle values, so a stale bus never looks valid
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1;
        {reg_rd, reg_addr} = {1'b0, ~a};
        v = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
    endtask
endmodule

// ==== dv/ccs_regs_tb.sv ====
`timescale 1ns/1ps
module ccs_regs_tb;
    logic clk, resetn, reg_wr, reg_rd, reg_rvalid, reg_reset_req, watchdog_expire;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] watchdog_period, charge_phase, thermistor_range_flags;
    logic [1:0] die_temp_limit_sel, ship_entry_delay_sel, c;
    logic [3:0] load_rail_target;
    logic [5:0] f;
    logic input_path_limiting, input_good_flag, die_temp_limiting_flag, input_fault_flag;
    logic overheat_shutdown_flag, cell_overvoltage_flag, charge_timeout_flag, safety_base_tick;
    logic ev_input_good, ev_charge_done, ev_thermistor, ev_cell_overvoltage, irq_event;
    logic thermistor_monitor_enable, safety_timer_tick, battery_switch_off, watchdog_active;
    logic board_overheat_enable, input_voltage_loop_enable, input_limit_release, input_limit_boost;
    logic [7:0] msk [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
    int fail_count = 0;
    int tests_run = 0;
    ccs_regs i_dut (
        .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .reg_reset_req, .watchdog_expire, .watchdog_period, .charge_phase, .input_path_limiting,
        .input_good_flag, .die_temp_limiting_flag, .input_fault_flag, .overheat_shutdown_flag,
        .cell_overvoltage_flag, .charge_timeout_flag, .thermistor_range_flags, .ev_input_good,
        .ev_charge_done, .ev_thermistor, .ev_cell_overvoltage, .safety_base_tick,
        .thermistor_monitor_enable, .safety_timer_tick, .battery_switch_off,
        .board_overheat_enable, .input_voltage_loop_enable, .die_temp_limit_sel,
        .load_rail_target, .input_limit_release, .input_limit_boost, .ship_entry_delay_sel,
        .watchdog_active, .irq_event
    );
    ccs_host_model i_host (.clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic irq_cnt(input int k, input logic [1:0] p, input logic [7:0] exp);
        int n;
        charge_phase = p;
        {ev_input_good, ev_charge_done, ev_thermistor, ev_cell_overvoltage} = 4'h8 >> k;
        @(posedge clk);
        #1;
        {ev_input_good, ev_charge_done, ev_thermistor, ev_cell_overvoltage} = 4'h0;
        n = 0;
        repeat (4) begin
            n += irq_event;
            @(posedge clk);
            #1;
        end
        chk(n[7:0], exp);
    endtask
    task automatic tick_cnt(input logic path, input logic [7:0] r6, input logic [7:0] exp);
        int n;
        i_host.wr(8'h06, r6);
        input_path_limiting = path;
        n = 0;
        // Eight one-cycle base ticks, so divider phase cannot skew the count
        repeat (16) begin
            safety_base_tick = ~safety_base_tick;
            @(posedge clk);
            #1;
            n += safety_timer_tick;
        end
        chk(n[7:0], exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write;
        i_host.wr(8'h06, 8'h3F);
        chk({thermistor_monitor_enable, battery_switch_off, 6'h0}, 8'h40);
        rchk(8'h06, 8'h3F);
        i_host.wr(8'h08, 8'hFF);
        chk({input_limit_release, input_limit_boost, 6'h0}, 8'hC0);
        rchk(8'h08, 8'h60);
        i_host.wr(8'h0A, 8'hFF);
        rchk(8'h0A, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            i_host.wr(8'h07, {2'h0, c, c, c});
            chk({die_temp_limit_sel, 2'h0, load_rail_target}, {c, 2'h0, c, c});
            i_host.wr(8'h09, {c, 6'h3F});
            chk({6'h0, ship_entry_delay_sel}, {6'h0, c});
            rchk(8'h09, {c, 6'h00});
        end
    endtask
    task automatic t_wdog;
        i_host.wr(8'h06, 8'hFF);
        i_host.wr(8'h07, 8'hFA);
        chk({board_overheat_enable, input_voltage_loop_enable, die_temp_limit_sel,
            load_rail_target}, 8'h3A);
        i_host.wr(8'h08, 8'h60);
        watchdog_expire = 1'b1;
        @(posedge clk);
        #1;
        watchdog_expire = 1'b0;
        rchk(8'h06, 8'hFF);
        rchk(8'h08, 8'h60);
        chk({7'h0, watchdog_active}, 8'h00);
        watchdog_period = 2'h3;
        chk({7'h0, watchdog_active}, 8'h01);
        watchdog_expire = 1'b1;
        @(posedge clk);
        #1;
        watchdog_expire = 1'b0;
        rchk(8'h06, 8'hE0);
        rchk(8'h07, 8'h3A);
        chk({board_overheat_enable, input_voltage_loop_enable, die_temp_limit_sel,
            load_rail_target}, 8'hFA);
        rchk(8'h08, 8'h80);
        rchk(8'h09, 8'hC0);
        i_host.wr(8'h08, 8'h00);
        rchk(8'h08, 8'h80);
        reg_reset_req = 1'b1;
        @(posedge clk);
        #1;
        reg_reset_req = 1'b0;
        rchk(8'h06, 8'hC0);
        rchk(8'h07, 8'h37);
        rchk(8'h08, 8'h00);
        rchk(8'h09, 8'h00);
    endtask
    task automatic t_status;
        for (int i = 0; i < 6; i++) begin
            f = 6'h01 << i;
            {input_fault_flag, overheat_shutdown_flag, cell_overvoltage_flag, charge_timeout_flag,
                thermistor_range_flags} = f;
            charge_phase = i[1:0];
            {input_path_limiting, input_good_flag, die_temp_limiting_flag} = i[2:0];
            i_host.wr(8'h08, 8'h1F);
            i_host.wr(8'h09, 8'h3F);
            rchk(8'h08, {3'h0, i[1:0], i[2:0]});
            rchk(8'h09, {2'h0, f});
        end
        {input_fault_flag, overheat_shutdown_flag, cell_overvoltage_flag, charge_timeout_flag,
            thermistor_range_flags, input_path_limiting, input_good_flag} = 8'h00;
        die_temp_limiting_flag = 1'b0;
    endtask
    task automatic t_irq;
        irq_cnt(4, 2'h0, 8'h01);
        for (int k = 0; k < 4; k++) begin
            irq_cnt(k, 2'h0, 8'h01);
            i_host.wr(8'h06, 8'hC0 | msk[k]);
            irq_cnt(k, 2'h0, 8'h00);
            i_host.wr(8'h06, 8'hC0);
        end
        irq_cnt(4, 2'h2, 8'h01);
        irq_cnt(4, 2'h3, 8'h00);
        i_host.wr(8'h06, 8'hC4);
        irq_cnt(4, 2'h1, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        // Run needs under three hundred cycles; 10000 cycles marks a hang
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {resetn, reg_reset_req, watchdog_expire, watchdog_period, charge_phase} = 7'h0;
        {input_fault_flag, overheat_shutdown_flag, cell_overvoltage_flag, charge_timeout_flag,
            thermistor_range_flags, input_path_limiting, input_good_flag} = 8'h00;
        {die_temp_limiting_flag, safety_base_tick} = 2'h0;
        {ev_input_good, ev_charge_done, ev_thermistor, ev_cell_overvoltage} = 4'h0;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        rchk(8'h06, 8'hC0);
        rchk(8'h07, 8'h37);
        t_write();
        t_wdog();
        t_status();
        t_irq();
        tick_cnt(1'b1, 8'hC0, 8'h04);
        tick_cnt(1'b1, 8'h80, 8'h08);
        tick_cnt(1'b0, 8'hC0, 8'h08);
        // Mid-run reset must bring back the defaults
        i_host.wr(8'h06, 8'h3F);
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        rchk(8'h06, 8'hC0);
        give_verdict();
    end
endmodule
